// ==== src/ubd_pkg.sv ====
package ubd_pkg;
    // ---------------------------------------------------------------
    // Descriptor status byte layout
    // ---------------------------------------------------------------
    localparam int BIT_OWN = 7;        // Engine owns descriptor
    localparam int BIT_TOGGLE = 6;     // Expected toggle, 1 = DATA1
    localparam int BIT_KEEP = 5;       // Keep descriptor
    localparam int BIT_STEP_OFF = 4;   // Address step off
    localparam int BIT_TCHK = 3;       // Toggle check on
    localparam int BIT_STALL = 2;      // Descriptor stall
    localparam int PID_LSB = 2;        // Token PID field low bit
    localparam int CNT_HI_LSB = 0;     // Count high bits low bit
    // ---------------------------------------------------------------
    // Descriptor memory geometry
    // ---------------------------------------------------------------
    localparam int AW = 10;            // Byte address width, 1 KB RAM
    localparam int DEPTH = 1024;       // Bytes of shared RAM
    localparam int CW = 10;            // Byte count width
    localparam logic [AW-1:0] OFS_CNT = 10'h001; // Count byte offset
    localparam logic [AW-1:0] OFS_ADL = 10'h002; // Address low offset
    localparam logic [AW-1:0] OFS_ADH = 10'h003; // Address high offset
    localparam logic [CW-1:0] CNT_ONE = 10'h001;
    localparam logic [AW-1:0] ADR_ONE = 10'h001;
    // ---------------------------------------------------------------
    // Token kinds and handshakes
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        TOK_OUT = 2'h0,
        TOK_IN = 2'h1,
        TOK_SETUP = 2'h2
    } ubd_tok_t;
    typedef enum logic [1:0] {
        HS_NONE = 2'h0,
        HS_ACK = 2'h1,
        HS_NAK = 2'h2,
        HS_STALL = 2'h3
    } ubd_hs_t;
    // Engine states, Gray along the usual path
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD0 = 3'b001,
        ST_RD1 = 3'b011,
        ST_RD2 = 3'b010,
        ST_RD3 = 3'b110,
        ST_DATA = 3'b111,
        ST_WB0 = 3'b101,
        ST_WB1 = 3'b100
    } ubd_state_t;
endpackage

// ==== src/ubd_handler.sv ====
// Overview of operation
// - Status bit 7 set means engine owns descriptor.
// - Status byte readable by either side anytime.
// - Engine clears ownership unless keep, stall, NAK or toggle mismatch.
// - Keep holds ownership, no status push, no irq.
// - Address step off keeps buffer address fixed.
// - Toggle mismatch: discard data, no done, ACK.
// - Toggle check off: accept either, full completion.
// - Expected toggle ignored unless checking enabled.
// - Stall bit: answer STALL, flag, irq, unchanged.
// - SETUP on stalled descriptor returns ownership.
// - Engine writes token PID and count back.
// - Ten-bit count, high bits in status 1:0.
// - IN sends count bytes, writes back sent count.
// - OUT count is limit, writes back received count.
// - OUT too long: NAK, count left unchanged.
// - Stalled flag holds until firmware clear, SETUP or reset.
module ubd_handler
    import ubd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // CPU port of the shared RAM
    input wire logic cpu_we,
    input wire logic [AW-1:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    // Token request from the link side
    input wire logic tok_valid,
    input wire ubd_tok_t tok_kind,
    input wire logic [3:0] tok_pid,
    input wire logic [AW-1:0] tok_bd_addr,
    output logic tok_busy,
    // Received OUT/SETUP bytes
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_last,
    input wire logic rx_data1,
    input wire logic rx_error,
    // Bytes sent for IN
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_last,
    input wire logic tx_ready,
    // Results
    output ubd_hs_t hs_code,
    output logic hs_valid,
    output logic transfer_done_flag,
    output logic status_push,
    output logic stall_irq,
    output logic endpoint_stalled_flag,
    input wire logic stalled_clear
);
    // ---------------------------------------------------------------
    // Shared RAM
    // ---------------------------------------------------------------
    logic [7:0] mem [DEPTH];  // Descriptors and buffers
    logic eng_we;             // Engine write strobe
    logic [AW-1:0] eng_addr;  // Engine address
    logic [7:0] eng_wdata;    // Engine write data
    logic [7:0] eng_rdata;    // Engine read data

    // Both ports each cycle; engine write wins a same-byte clash
    // since firmware may not touch engine-owned bytes anyway
    always_ff @(posedge clk) begin
        if (ce) begin
            if (cpu_we && !(eng_we && eng_addr == cpu_addr)) begin
                mem[cpu_addr] <= cpu_wdata;
            end
            if (eng_we) begin
                mem[eng_addr] <= eng_wdata;
            end
            cpu_rdata <= mem[cpu_addr];
            eng_rdata <= mem[eng_addr];
        end
    end

    // ---------------------------------------------------------------
    // Engine state
    // ---------------------------------------------------------------
    ubd_state_t st_r, st_nxt;          // Sequencer
    logic [7:0] stat_r, stat_nxt;      // Latched status byte
    logic [CW-1:0] lim_r, lim_nxt;     // Byte count limit
    logic [CW-1:0] cnt_r, cnt_nxt;     // Bytes moved
    logic [AW-1:0] bd_r, bd_nxt;       // Descriptor base
    logic [AW-1:0] ptr_r, ptr_nxt;     // Buffer pointer
    ubd_tok_t kind_r, kind_nxt;        // Token kind
    logic [3:0] pid_r, pid_nxt;        // Token PID
    logic bad_r, bad_nxt;              // Toggle mismatch
    logic over_r, over_nxt;            // Overlong or error
    logic txw_r, txw_nxt;              // IN byte fetched, waiting
    logic [7:0] txd_r, txd_nxt;        // IN byte register
    logic txl_r, txl_nxt;              // IN last flag
    ubd_hs_t hs_r, hs_nxt;
    logic hsv_r, hsv_nxt;
    logic done_r, done_nxt;
    logic push_r, push_nxt;
    logic sirq_r, sirq_nxt;
    logic stl_r, stl_nxt;

    // Next-state logic of the sequencer
    always_comb begin
        st_nxt = st_r;
        stat_nxt = stat_r;
        lim_nxt = lim_r;
        cnt_nxt = cnt_r;
        bd_nxt = bd_r;
        ptr_nxt = ptr_r;
        kind_nxt = kind_r;
        pid_nxt = pid_r;
        bad_nxt = bad_r;
        over_nxt = over_r;
        txw_nxt = txw_r;
        txd_nxt = txd_r;
        txl_nxt = txl_r;
        hs_nxt = HS_NONE;
        hsv_nxt = 1'b0;
        done_nxt = 1'b0;
        push_nxt = 1'b0;
        sirq_nxt = 1'b0;
        eng_we = 1'b0;
        eng_addr = bd_r;
        eng_wdata = 8'h00;
        // Stalled flag: a new stall wins over a firmware clear
        stl_nxt = stalled_clear ? 1'b0 : stl_r;
        unique case (st_r)
            ST_IDLE: begin
                // Take a token and start reading its descriptor
                if (tok_valid) begin
                    bd_nxt = tok_bd_addr;
                    eng_addr = tok_bd_addr;
                    kind_nxt = tok_kind;
                    pid_nxt = tok_pid;
                    st_nxt = ST_RD0;
                end
            end
            ST_RD0: begin
                // Status byte arrives; count byte requested
                stat_nxt = eng_rdata;
                eng_addr = bd_r + OFS_CNT;
                st_nxt = ST_RD1;
                if (!eng_rdata[BIT_OWN]) begin
                    // Firmware owns it: not armed, refuse
                    hs_nxt = HS_NAK;
                    hsv_nxt = 1'b1;
                    st_nxt = ST_IDLE;
                end else if (eng_rdata[BIT_STALL]) begin
                    if (kind_r == TOK_SETUP) begin
                        // SETUP lifts the stall, back to firmware
                        eng_we = 1'b1;
                        eng_addr = bd_r;
                        eng_wdata = 8'h00;
                        stl_nxt = 1'b0;
                        hs_nxt = HS_NAK;
                        hsv_nxt = 1'b1;
                    end else begin
                        // Answer STALL, descriptor untouched
                        hs_nxt = HS_STALL;
                        hsv_nxt = 1'b1;
                        sirq_nxt = 1'b1;
                        stl_nxt = 1'b1;
                    end
                    st_nxt = ST_IDLE;
                end
            end
            ST_RD1: begin
                // Count low byte arrives; limit from both bytes
                lim_nxt = {stat_r[CNT_HI_LSB+1:CNT_HI_LSB],
                    eng_rdata};
                eng_addr = bd_r + OFS_ADL;
                st_nxt = ST_RD2;
            end
            ST_RD2: begin
                // Address low byte arrives; high byte requested
                ptr_nxt[7:0] = eng_rdata;
                eng_addr = bd_r + OFS_ADH;
                st_nxt = ST_RD3;
            end
            ST_RD3: begin
                // Address high byte arrives; first buffer byte asked
                // for now so an IN byte is ready in the next cycle
                ptr_nxt[AW-1:8] = eng_rdata[AW-9:0];
                eng_addr = {eng_rdata[AW-9:0], ptr_r[7:0]};
                st_nxt = ST_DATA;
                cnt_nxt = '0;
                bad_nxt = 1'b0;
                over_nxt = 1'b0;
                txw_nxt = 1'b0;
            end
            ST_DATA: begin
                eng_addr = ptr_r;
                if (kind_r == TOK_IN) begin
                    // Send exactly the programmed count
                    if (lim_r == '0) begin
                        txd_nxt = 8'h00;
                        txl_nxt = 1'b1;
                        st_nxt = ST_WB0;
                    end else if (!txw_r) begin
                        txw_nxt = 1'b1;
                        txd_nxt = eng_rdata;
                        txl_nxt = (cnt_r + CNT_ONE == lim_r);
                    end else if (tx_ready) begin
                        txw_nxt = 1'b0;
                        cnt_nxt = cnt_r + CNT_ONE;
                        if (!stat_r[BIT_STEP_OFF]) begin
                            ptr_nxt = ptr_r + ADR_ONE;
                        end
                        if (txl_r) begin
                            st_nxt = ST_WB0;
                        end
                    end
                    // Next byte fetched as the pointer moves, no stale read
                    eng_addr = ptr_nxt;
                end else if (rx_valid) begin
                    // Toggle compared only when checking is on
                    if (stat_r[BIT_TCHK]
                        && rx_data1 != stat_r[BIT_TOGGLE]) begin
                        bad_nxt = 1'b1;
                    end
                    if (cnt_r >= lim_r || rx_error) begin
                        over_nxt = 1'b1;
                    end
                    if (!bad_nxt && !over_nxt) begin
                        eng_we = 1'b1;
                        eng_wdata = rx_byte;
                        cnt_nxt = cnt_r + CNT_ONE;
                        if (!stat_r[BIT_STEP_OFF]) begin
                            ptr_nxt = ptr_r + ADR_ONE;
                        end
                    end
                    if (rx_last) begin
                        st_nxt = ST_WB0;
                    end
                end
            end
            ST_WB0: begin
                st_nxt = ST_IDLE;
                hsv_nxt = 1'b1;
                hs_nxt = HS_ACK;
                if (over_r) begin
                    hs_nxt = HS_NAK;
                end else if (!bad_r) begin
                    // Count low byte written back
                    eng_we = 1'b1;
                    eng_addr = bd_r + OFS_CNT;
                    eng_wdata = cnt_r[7:0];
                    if (!stat_r[BIT_KEEP]) begin
                        st_nxt = ST_WB1;
                    end
                end
            end
            ST_WB1: begin
                // Status rewrite: PID and count, ownership back
                eng_we = 1'b1;
                eng_addr = bd_r;
                eng_wdata = {1'b0, 1'b0, pid_r, cnt_r[CW-1:8]};
                done_nxt = 1'b1;
                push_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // Register stage of the sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= ST_IDLE;
            stat_r <= 8'h00;
            lim_r <= '0;
            cnt_r <= '0;
            bd_r <= '0;
            ptr_r <= '0;
            kind_r <= TOK_OUT;
            pid_r <= 4'h0;
            bad_r <= 1'b0;
            over_r <= 1'b0;
            txw_r <= 1'b0;
            txd_r <= 8'h00;
            txl_r <= 1'b0;
            hs_r <= HS_NONE;
            hsv_r <= 1'b0;
            done_r <= 1'b0;
            push_r <= 1'b0;
            sirq_r <= 1'b0;
            stl_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            stat_r <= stat_nxt;
            lim_r <= lim_nxt;
            cnt_r <= cnt_nxt;
            bd_r <= bd_nxt;
            ptr_r <= ptr_nxt;
            kind_r <= kind_nxt;
            pid_r <= pid_nxt;
            bad_r <= bad_nxt;
            over_r <= over_nxt;
            txw_r <= txw_nxt;
            txd_r <= txd_nxt;
            txl_r <= txl_nxt;
            hs_r <= hs_nxt;
            hsv_r <= hsv_nxt;
            done_r <= done_nxt;
            push_r <= push_nxt;
            sirq_r <= sirq_nxt;
            stl_r <= stl_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign tok_busy = (st_r != ST_IDLE);
    assign tx_valid = txw_r && (st_r == ST_DATA);
    assign tx_byte = txd_r;
    assign tx_last = txl_r;
    assign hs_code = hs_r;
    assign hs_valid = hsv_r;
    assign transfer_done_flag = done_r;
    assign status_push = push_r;
    assign stall_irq = sirq_r;
    assign endpoint_stalled_flag = stl_r;
endmodule

// ==== tb/ubd_handler_properties.sv ====
module ubd_handler_chk
    import ubd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic tok_valid,
    input wire logic tok_busy,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire ubd_hs_t hs_code,
    input wire logic hs_valid,
    input wire logic transfer_done_flag,
    input wire logic status_push,
    input wire logic stall_irq,
    input wire logic endpoint_stalled_flag,
    input wire logic stalled_clear
);
    timeunit 1ns;
    timeprecision 1ns;
    // -----------------------------------------------------------
    // Clocking and helper state
    // -----------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    // Frozen cycles stretch pulses, so they are not judged
    default disable iff (srst || !ce);
    ubd_hs_t last_hs_r; // Last answer code given
    ubd_hs_t last_hs_nxt;
    ubd_hs_t seen_hs; // Answer now, else the last one
    // Next value of the held answer
    always_comb begin
        last_hs_nxt = hs_valid ? hs_code : last_hs_r;
        seen_hs = last_hs_nxt;
    end
    // Register only
    always_ff @(posedge clk) begin
        last_hs_r <= srst ? HS_NONE : last_hs_nxt;
    end
    // -----------------------------------------------------------
    // Properties
    // -----------------------------------------------------------
    tok_take_a: assert property (tok_valid && !tok_busy |=> tok_busy)
        else $error("token not taken");
    hs_pulse_a: assert property (hs_valid |=> !hs_valid)
        else $error("answer pulse too long");
    done_push_a: assert property (transfer_done_flag == status_push)
        else $error("done and status push differ");
    done_ack_a: assert property (transfer_done_flag |-> seen_hs == HS_ACK)
        else $error("done without ACK");
    stall_code_a: assert property (
        stall_irq |-> ##[0:2] (seen_hs == HS_STALL))
        else $error("stall irq without STALL");
    stall_flag_a: assert property (
        stall_irq && !stalled_clear |=> endpoint_stalled_flag)
        else $error("stalled flag not set");
    flag_hold_a: assert property (
        endpoint_stalled_flag && !stalled_clear && !tok_busy
        |=> endpoint_stalled_flag) else $error("stalled flag dropped");
    tx_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("IN byte not held");
    tx_busy_a: assert property (tx_valid |-> tok_busy)
        else $error("IN byte while idle");
    in_last_a: assert property (
        tx_valid && tx_ready && tx_last |=> !tx_valid)
        else $error("IN byte after the last one");
    reset_quiet_a: assert property ($past(srst) |->
        !tok_busy && !hs_valid && !endpoint_stalled_flag)
        else $error("outputs not quiet after reset");
    cover property (transfer_done_flag);
    cover property (stall_irq);
    cover property (tx_valid && !tx_ready);
endmodule
bind ubd_handler ubd_handler_chk chk_i (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .tok_valid(tok_valid),
    .tok_busy(tok_busy),
    .tx_valid(tx_valid),
    .tx_byte(tx_byte),
    .tx_last(tx_last),
    .tx_ready(tx_ready),
    .hs_code(hs_code),
    .hs_valid(hs_valid),
    .transfer_done_flag(transfer_done_flag),
    .status_push(status_push),
    .stall_irq(stall_irq),
    .endpoint_stalled_flag(endpoint_stalled_flag),
    .stalled_clear(stalled_clear)
);

// ==== tb/ubd_host_model.sv ====
module ubd_host_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_ready,
    output logic [7:0] last_rx,
    output logic [9:0] n_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    // -----------------------------------------------------------
    // Host side of IN data: slow mode stalls every other cycle
    // -----------------------------------------------------------
    initial begin
        tx_ready = 1'b0;
        n_rx = 10'h000;
        last_rx = 8'h00;
    end
    // Take a byte only at an edge where both sides agree
    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            n_rx <= n_rx + 10'h001;
            last_rx <= tx_byte;
        end
        tx_ready <= #1 slow ? ~tx_ready : 1'b1;
    end
endmodule

// ==== tb/testbench.sv ====
module testbench
    import ubd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // -----------------------------------------------------------
    // Signals, all inputs set at time zero
    // -----------------------------------------------------------
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1, cpu_we = 1'b0;
    logic tok_valid = 1'b0, rx_valid = 1'b0, rx_last = 1'b0;
    logic rx_data1 = 1'b0, rx_error = 1'b0, stalled_clear = 1'b0;
    logic slow = 1'b0;
    logic [AW-1:0] cpu_addr = 10'h000, tok_bd_addr = 10'h000;
    logic [7:0] cpu_wdata = 8'h00, rx_byte = 8'h00;
    logic [7:0] cpu_rdata, tx_byte, last_rx;
    logic [3:0] tok_pid = 4'h0;
    ubd_tok_t tok_kind = TOK_OUT;
    ubd_hs_t hs_code, last_hs;
    logic tok_busy, tx_valid, tx_last, tx_ready, hs_valid;
    logic transfer_done_flag, status_push, stall_irq;
    logic endpoint_stalled_flag;
    logic [9:0] n_done, n_push, n_stall, n_rx, n_base;
    int n_fail = 0;
    int tests_run = 0;
    localparam logic [AW-1:0] BUF = 10'h100; // Data buffer base
    ubd_handler uut (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .cpu_we(cpu_we),
        .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata),
        .tok_valid(tok_valid),
        .tok_kind(tok_kind),
        .tok_pid(tok_pid),
        .tok_bd_addr(tok_bd_addr),
        .tok_busy(tok_busy),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .rx_last(rx_last),
        .rx_data1(rx_data1),
        .rx_error(rx_error),
        .tx_valid(tx_valid),
        .tx_byte(tx_byte),
        .tx_last(tx_last),
        .tx_ready(tx_ready),
        .hs_code(hs_code),
        .hs_valid(hs_valid),
        .transfer_done_flag(transfer_done_flag),
        .status_push(status_push),
        .stall_irq(stall_irq),
        .endpoint_stalled_flag(endpoint_stalled_flag),
        .stalled_clear(stalled_clear)
    );
    ubd_host_model host (
        .clk(clk),
        .slow(slow),
        .tx_valid(tx_valid),
        .tx_byte(tx_byte),
        .tx_ready(tx_ready),
        .last_rx(last_rx),
        .n_rx(n_rx)
    );
    // Clock at 50 ns
    initial begin
        forever #25 clk = ~clk;
    end
    // Tally of pulses seen since the last token
    always @(posedge clk) begin
        if (hs_valid === 1'b1) last_hs <= hs_code;
        if (transfer_done_flag === 1'b1) n_done <= n_done + 10'h001;
        if (status_push === 1'b1) n_push <= n_push + 10'h001;
        if (stall_irq === 1'b1) n_stall <= n_stall + 10'h001;
    end
    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task conclude;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [9:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_we = 1'b1;
        step();
        cpu_we = 1'b0;
        step(); // Strobe low for one edge between writes
    endtask
    // Read data is registered: one edge after the address
    task rdc(input logic [9:0] a, input logic [7:0] e);
        cpu_addr = a;
        step();
        chk("ram byte", {2'h0, cpu_rdata}, {2'h0, e});
    endtask
    // Count and address first, status byte last
    task arm(input logic [7:0] st, cnt);
        wr(OFS_CNT, cnt);
        wr(OFS_ADL, BUF[7:0]);
        wr(OFS_ADH, {6'h00, BUF[9:8]});
        wr(10'h000, st);
    endtask
    // One token; OUT bytes follow once the descriptor is fetched
    task tok(input ubd_tok_t k, input logic [3:0] p, input int n,
        input logic d1, e);
        int i;
        last_hs = HS_NONE;
        {n_done, n_push, n_stall} = 30'h0;
        n_base = n_rx;
        tok_kind = k;
        tok_pid = p;
        tok_valid = 1'b1;
        step();
        tok_valid = 1'b0;
        step(6);
        for (i = 0; i < n; i++) begin
            rx_valid = 1'b1;
            rx_byte = 8'hA0 + 8'(i);
            rx_last = (i == n - 1);
            rx_data1 = d1;
            rx_error = e && rx_last;
            step();
        end
        {rx_valid, rx_last, rx_error} = 3'h0;
        rx_byte = ~rx_byte; // Released line shows no stale byte
        for (i = 0; i < 2000 && tok_busy !== 1'b0; i++) step();
        step(2);
    endtask
    task res(input ubd_hs_t h, input logic [9:0] d, s);
        chk("handshake", {8'h00, last_hs}, {8'h00, h});
        chk("done", n_done, d);
        chk("push", n_push, d);
        chk("stall irq", n_stall, s);
    endtask
    // -----------------------------------------------------------
    // Sequence of tests
    // -----------------------------------------------------------
    initial begin
        step(6);
        srst = 1'b0;
        chk("stalled", {9'h0, endpoint_stalled_flag}, 10'h000);
        wr(10'h200, 8'h5A);
        rdc(10'h200, 8'h5A);
        ce = 1'b0; // Frozen: this write must not land
        wr(10'h200, 8'h77);
        ce = 1'b1;
        rdc(10'h200, 8'h5A);
        arm(8'h00, 8'h08);
        tok(TOK_OUT, 4'h1, 3, 1'b0, 1'b0);
        res(HS_NAK, 10'h000, 10'h000);
        arm(8'hC1, 8'h05);
        tok(TOK_OUT, 4'h1, 3, 1'b0, 1'b0);
        res(HS_ACK, 10'h001, 10'h000);
        rdc(10'h000, {2'h0, 4'h1, 2'h0});
        rdc(OFS_CNT, 8'h03);
        rdc(BUF + 10'h002, 8'hA2);
        wr(BUF, 8'h11);
        arm(8'h88, 8'h08);
        tok(TOK_OUT, 4'h1, 2, 1'b1, 1'b0);
        res(HS_ACK, 10'h000, 10'h000);
        rdc(10'h000, 8'h88);
        rdc(BUF, 8'h11);
        arm(8'hC8, 8'h08);
        tok(TOK_OUT, 4'h1, 2, 1'b1, 1'b0);
        res(HS_ACK, 10'h001, 10'h000);
        arm(8'h80, 8'h02);
        tok(TOK_OUT, 4'h1, 3, 1'b0, 1'b0);
        res(HS_NAK, 10'h000, 10'h000);
        rdc(OFS_CNT, 8'h02);
        arm(8'h80, 8'h08);
        tok(TOK_OUT, 4'h1, 2, 1'b0, 1'b1);
        res(HS_NAK, 10'h000, 10'h000);
        rdc(10'h000, 8'h80);
        wr(BUF + 10'h001, 8'h33);
        arm(8'h90, 8'h08);
        tok(TOK_OUT, 4'h1, 3, 1'b0, 1'b0);
        res(HS_ACK, 10'h001, 10'h000);
        rdc(BUF, 8'hA2);
        rdc(BUF + 10'h001, 8'h33);
        arm(8'hA0, 8'h08);
        tok(TOK_OUT, 4'h1, 2, 1'b0, 1'b0);
        res(HS_ACK, 10'h000, 10'h000);
        rdc(10'h000, 8'hA0);
        for (int j = 0; j < 4; j++) wr(BUF + 10'(j), 8'hC0 + 8'(j));
        arm(8'h80, 8'h04);
        slow = 1'b1;
        tok(TOK_IN, 4'h9, 0, 1'b0, 1'b0);
        res(HS_ACK, 10'h001, 10'h000);
        chk("in bytes", n_rx - n_base, 10'h004);
        chk("in last", {2'h0, last_rx}, 10'h0C3);
        rdc(10'h000, {2'h0, 4'h9, 2'h0});
        rdc(OFS_CNT, 8'h04);
        arm(8'h84, 8'h04);
        tok(TOK_IN, 4'h9, 0, 1'b0, 1'b0);
        res(HS_STALL, 10'h000, 10'h001);
        rdc(10'h000, 8'h84);
        step(20);
        chk("stalled", {9'h0, endpoint_stalled_flag}, 10'h001);
        tok(TOK_SETUP, 4'hD, 0, 1'b0, 1'b0);
        rdc(10'h000, 8'h00);
        chk("stalled", {9'h0, endpoint_stalled_flag}, 10'h000);
        arm(8'h84, 8'h04);
        tok(TOK_IN, 4'h9, 0, 1'b0, 1'b0);
        stalled_clear = 1'b1;
        step();
        stalled_clear = 1'b0;
        step();
        chk("stalled", {9'h0, endpoint_stalled_flag}, 10'h000);
        conclude();
    end
    // Whole run is near 300 cycles; this leaves wide margin
    initial begin
        #400000;
        n_fail++;
        conclude();
    end
endmodule
